// ---- logic/carvr_cmd_rx.sv ----
// Serial command deserialiser, one bit per link bit-clock rise
`timescale 1ns/100ps
module carvr_cmd_rx
   import carvr_pkg::*;
(
   input  wire logic   clock_i,
   input  wire logic   rst_i,
   carvr_link_if.rx    lnk
);
   logic [39:0] shift_q;
   logic [5:0]  count_q;
   logic        active_q;
   logic        valid_q;

   wire last_bit = active_q && lnk.bit_rise &&
                   (count_q == 6'(CMD_BITS - 1));

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         shift_q  <= 40'h0;
         count_q  <= 6'h0;
         active_q <= 1'b0;
         valid_q  <= 1'b0;
      end
      else
      begin
         valid_q <= last_bit;
         if (lnk.frame_start)
         begin
            active_q <= 1'b1;
            count_q  <= 6'h0;
         end
         else if (active_q && lnk.bit_rise)
         begin
            shift_q  <= {shift_q[38:0], lnk.sdo_bit};
            count_q  <= count_q + 6'h1;
            active_q <= !last_bit;
         end
      end
   end

   assign lnk.cmd_valid = valid_q;
   assign lnk.cmd_word  = shift_q;
endmodule : carvr_cmd_rx

// ---- logic/carvr_link_if.sv ----
// Bit strobes, command word and response word shared inside the responder
`timescale 1ns/100ps
interface carvr_link_if;
   logic        bit_rise;
   logic        frame_start;
   logic        sdo_bit;
   logic        cmd_valid;
   logic [39:0] cmd_word;
   logic        resp_valid;
   logic [35:0] resp_word;
   logic        resp_taken;
   logic        sdi_bit;
   logic        sdi_oe;

   modport rx   (input bit_rise, frame_start, sdo_bit,
                 output cmd_valid, cmd_word);
   modport tx   (input bit_rise, frame_start, resp_valid, resp_word,
                 output resp_taken, sdi_bit, sdi_oe);
   modport core (output bit_rise, frame_start, sdo_bit, resp_valid,
                 resp_word,
                 input cmd_valid, cmd_word, resp_taken, sdi_bit, sdi_oe);
endinterface : carvr_link_if

// ---- logic/carvr_pkg.sv ----
// Constants shared by the codec root and audio group verb responder
package carvr_pkg;

   // Link framing
   localparam int CMD_BITS  = 40;
   localparam int RESP_BITS = 36;
   localparam int RESP_VALID_POS = 35;
   localparam int RESP_UNSOL_POS = 34;
   localparam int UNSOL_TAG_POS  = 26;

   // Command word fields
   localparam int CMD_ADDR_POS = 28;
   localparam int CMD_NODE_POS = 20;
   localparam int CMD_VERB_POS = 8;

   // Twelve-bit verbs
   localparam logic [11:0] VERB_GET_PARAM   = 12'hF00;
   localparam logic [11:0] VERB_GET_POWER   = 12'hF05;
   localparam logic [11:0] VERB_SET_POWER   = 12'h705;
   localparam logic [11:0] VERB_GET_UNSOL   = 12'hF08;
   localparam logic [11:0] VERB_SET_UNSOL   = 12'h708;
   localparam logic [11:0] VERB_GET_GDATA   = 12'hF15;
   localparam logic [11:0] VERB_SET_GDATA   = 12'h715;
   localparam logic [11:0] VERB_GET_GENABLE = 12'hF16;
   localparam logic [11:0] VERB_SET_GENABLE = 12'h716;
   localparam logic [11:0] VERB_GET_GDIR    = 12'hF17;
   localparam logic [11:0] VERB_SET_GDIR    = 12'h717;
   localparam logic [11:0] VERB_GET_GMASK   = 12'hF19;
   localparam logic [11:0] VERB_SET_GMASK   = 12'h719;
   localparam logic [11:0] VERB_GET_BOARD   = 12'hF20;
   localparam logic [11:0] VERB_SET_BOARD0  = 12'h720;
   localparam logic [11:0] VERB_GET_VCFG    = 12'hF83;
   localparam logic [11:0] VERB_SET_VCFG    = 12'h783;
   localparam logic [11:0] VERB_FUNC_RESET  = 12'h7FF;

   // Get-parameter selectors
   localparam logic [7:0] PARAM_IDENT   = 8'h00;
   localparam logic [7:0] PARAM_REV     = 8'h02;
   localparam logic [7:0] PARAM_CHILD   = 8'h04;
   localparam logic [7:0] PARAM_TYPE    = 8'h05;
   localparam logic [7:0] PARAM_GCAPS   = 8'h08;
   localparam logic [7:0] PARAM_WCAPS   = 8'h09;
   localparam logic [7:0] PARAM_PSTATES = 8'h0F;
   localparam logic [7:0] PARAM_GPIOCAP = 8'h11;

   // Fixed parameter answers
   localparam logic [31:0] REVISION_PARAM     = 32'h0010_0000;
   localparam logic [31:0] ROOT_CHILD_COUNT   = 32'h0001_0001;
   localparam logic [31:0] GROUP_CHILD_COUNT  = 32'h0008_002E;
   localparam logic [31:0] GROUP_TYPE_PARAM   = 32'h0000_0001;
   localparam logic [31:0] GROUP_CAPS_PARAM   = 32'h0001_0306;
   localparam logic [31:0] POWER_STATES_PARAM = 32'hC000_000F;
   localparam logic [31:0] GPIO_CAPS_BASE     = 32'h4000_0000;
   localparam logic [31:0] OUT_CONVERTER_CAPS = 32'h0000_041D;
   localparam logic [31:0] POWER_FIXED_BITS   = 32'h0000_0400;

   // Node map
   localparam logic [6:0] NODE_ROOT     = 7'h00;
   localparam logic [6:0] NODE_GROUP    = 7'h01;
   localparam logic [6:0] NODE_FIRST    = 7'h08;
   localparam logic [6:0] NODE_LAST     = 7'h35;
   localparam logic [6:0] OUTCONV_LAST  = 7'h0C;

   // Field positions and reset values
   localparam int          POWER_ACT_POS  = 4;
   localparam int          UNSOL_EN_POS   = 7;
   localparam int          VCFG_TX2_POS   = 4;
   localparam logic [3:0]  POWER_RST      = 4'h0;
   localparam logic [7:0]  POWER_MAX_SEL  = 8'h03;
   localparam logic [3:0]  POWER_D1       = 4'h1;
   localparam logic [7:0]  UNSOL_RST      = 8'h00;
   localparam logic [7:0]  UNSOL_WR_MASK  = 8'hBF;
   localparam logic [7:0]  VCFG_RST       = 8'h10;
   localparam logic [1:0]  GPIO_RST       = 2'h0;

endpackage : carvr_pkg

// ---- logic/carvr_resp_tx.sv ----
// Response serialiser: one queued word per frame, MSB first
`timescale 1ns/100ps
module carvr_resp_tx
   import carvr_pkg::*;
(
   input  wire logic   clock_i,
   input  wire logic   rst_i,
   carvr_link_if.tx    lnk
);
   typedef enum logic {TX_IDLE, TX_SHIFT} carvr_tx_state_t;

   carvr_tx_state_t state_q;
   logic [35:0]     shift_q;
   logic [5:0]      count_q;

   assign lnk.resp_taken = (state_q == TX_IDLE) && lnk.frame_start &&
                           lnk.resp_valid;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= TX_IDLE;
         shift_q <= 36'h0;
         count_q <= 6'h0;
      end
      else
      begin
         case (state_q)
            TX_IDLE:
            begin
               if (lnk.resp_taken)
               begin
                  shift_q <= lnk.resp_word;
                  count_q <= 6'h0;
                  state_q <= TX_SHIFT;
               end
            end
            TX_SHIFT:
            begin
               if (lnk.bit_rise)
               begin
                  shift_q <= {shift_q[34:0], 1'b0};
                  count_q <= count_q + 6'h1;
                  if (count_q == 6'(RESP_BITS - 1))
                     state_q <= TX_IDLE;
               end
            end
            default: state_q <= TX_IDLE;
         endcase
      end
   end

   assign lnk.sdi_bit = shift_q[35];
   assign lnk.sdi_oe  = (state_q == TX_SHIFT);
endmodule : carvr_resp_tx

// ---- logic/carvr_responder.sv ----
// Root node and audio group verb responder on the serial audio link
//
// How it works
// - Identification parameter returns maker code high, part code low.
// - Revision parameter reports major level one, all else zero.
// - Root child count: start node one, one subordinate node.
// - Group child count: start node 08h, 2Eh widget nodes.
// - Group type returns 01h, audio, no group unsolicited support.
// - Group caps: beep generator, input delay 3h, output delay 6h.
// - Power states parameter returns C000000Fh.
// - GPIO caps: pin change reports, no wake, pin count in 7:0.
// - Pin count is two while vendor config bit 4 is zero.
// - Board identifier read whole, written byte by byte 720h-723h.
// - All 32 identifier bits writable with a fixed default.
// - Power read by F05h, set by 705h with payload 0 to 3.
// - Actual state mirrors requested; settings-lost reads one.
// - Unsolicited control byte: enable, reserved bit, six-bit tag.
// - GPIO data drives output pins only; read returns pin levels.
// - Disabled GPIO pins float; enabled ones follow direction.
// - Direction bit zero is input, one is output; reset input.
// - Masked pin changes raise an unsolicited report.
// - Verb 7FFh with zero payload resets the audio group.
// - Vendor verbs F70h to FBCh carry no behaviour, bar vendor config F83h/783h.
// - Nodes 00, 01 and 08 to 35 answer; others stay silent.
// - Output converters 08-0C report type zero, zero delay.
// - D1 drops amplifiers; D2, D3 drop reference as well.
`timescale 1ns/100ps
module carvr_responder
   import carvr_pkg::*;
#(
   // Arbitrary identity values, not those of any real part
   parameter logic [15:0] MAKER_CODE = 16'h5A5A,
   parameter logic [15:0] PART_CODE  = 16'h0C0D,
   parameter logic [3:0]  CODEC_ADDR = 4'h0,
   parameter int          GPIO_PINS  = 2
)
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       link_bclk_i,
   input  wire logic       link_sync_i,
   input  wire logic       link_sdo_i,
   output logic            link_sdi_o,
   output logic            link_sdi_oe_o,
   input  wire logic [1:0] gpio_i,
   output logic      [1:0] gpio_o,
   output logic      [1:0] gpio_oe_o,
   output logic            second_digital_audio_out_o,
   output logic      [3:0] requested_power_state_o,
   output logic            amp_power_on_o,
   output logic            ref_power_on_o
);

   if (GPIO_PINS != 2)
   begin : g_bad_pins
      $error("carvr_responder serves exactly two GPIO pins");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and link strobes

   // Order: bit clock, frame sync, serial data out, gpio 1:0
   wire  [4:0] pins_raw = {link_bclk_i, link_sync_i, link_sdo_i, gpio_i};
   logic [4:0] pins_meta_q;
   logic [4:0] pins_q;
   logic       bclk_prev_q;
   logic       sync_prev_q;
   logic [1:0] gpio_prev_q;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pins_meta_q <= 5'h00;
         pins_q      <= 5'h00;
      end
      else
      begin
         pins_meta_q <= pins_raw;
         pins_q      <= pins_meta_q;
      end
   end

   wire       bclk_s = pins_q[4];
   wire       sync_s = pins_q[3];
   wire       sdo_s  = pins_q[2];
   wire [1:0] gpio_s = pins_q[1:0];

   // The bit clock is oversampled eight times, so edge finding is exact
   wire bit_rise    = bclk_s && !bclk_prev_q;
   wire frame_start = bit_rise && sync_prev_q && !sync_s;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bclk_prev_q <= 1'b0;
         sync_prev_q <= 1'b0;
      end
      else
      begin
         bclk_prev_q <= bclk_s;
         if (bit_rise)
            sync_prev_q <= sync_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link serialisers

   carvr_link_if lnk ();

   assign lnk.bit_rise    = bit_rise;
   assign lnk.frame_start = frame_start;
   assign lnk.sdo_bit     = sdo_s;

   carvr_cmd_rx u_rx
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .lnk     (lnk.rx)
   );

   carvr_resp_tx u_tx
   (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .lnk     (lnk.tx)
   );

   assign link_sdi_o    = lnk.sdi_bit;
   assign link_sdi_oe_o = lnk.sdi_oe;

   ////////////////////////////////////////////////////////////////////////
   // Command decode

   wire [3:0]  cmd_addr = lnk.cmd_word[CMD_ADDR_POS +: 4];
   wire [6:0]  cmd_node = lnk.cmd_word[CMD_NODE_POS +: 7];
   wire [11:0] cmd_verb = lnk.cmd_word[CMD_VERB_POS +: 12];
   wire [7:0]  cmd_pay  = lnk.cmd_word[7:0];

   wire for_me     = lnk.cmd_valid && (cmd_addr == CODEC_ADDR);
   wire is_root    = (cmd_node == NODE_ROOT);
   wire is_group   = (cmd_node == NODE_GROUP);
   wire is_widget  = (cmd_node >= NODE_FIRST) && (cmd_node <= NODE_LAST);
   wire is_outconv = (cmd_node >= NODE_FIRST) && (cmd_node <= OUTCONV_LAST);
   wire in_map     = is_root || is_group || is_widget;

   wire grp_cmd    = for_me && is_group;
   wire wr_power   = grp_cmd && (cmd_verb == VERB_SET_POWER) &&
                     (cmd_pay <= POWER_MAX_SEL);
   wire wr_unsol   = grp_cmd && (cmd_verb == VERB_SET_UNSOL);
   wire wr_gdata   = grp_cmd && (cmd_verb == VERB_SET_GDATA);
   wire wr_genable = grp_cmd && (cmd_verb == VERB_SET_GENABLE);
   wire wr_gdir    = grp_cmd && (cmd_verb == VERB_SET_GDIR);
   wire wr_gmask   = grp_cmd && (cmd_verb == VERB_SET_GMASK);
   wire wr_vcfg    = grp_cmd && (cmd_verb == VERB_SET_VCFG);
   wire wr_board   = grp_cmd &&
                     (cmd_verb[11:2] == VERB_SET_BOARD0[11:2]);
   wire fn_reset   = grp_cmd && (cmd_verb == VERB_FUNC_RESET) &&
                     (cmd_pay == 8'h00);

   ////////////////////////////////////////////////////////////////////////
   // Audio group state

   logic [31:0] board_id_q;
   logic [3:0]  power_q;
   logic [7:0]  unsol_q;
   logic [7:0]  vcfg_q;
   logic [1:0]  gdata_q;
   logic [1:0]  genable_q;
   logic [1:0]  gdir_q;
   logic [1:0]  gmask_q;

   // The board identifier survives a function reset: firmware sets it once
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         board_id_q <= {MAKER_CODE, 16'h0000};
      else if (wr_board)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (cmd_verb[1:0] == 2'(b))
               board_id_q[8*b +: 8] <= cmd_pay;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         power_q   <= POWER_RST;
         unsol_q   <= UNSOL_RST;
         gdata_q   <= GPIO_RST;
         genable_q <= GPIO_RST;
         gdir_q    <= GPIO_RST;
         gmask_q   <= GPIO_RST;
      end
      else if (fn_reset)
      begin
         power_q   <= POWER_RST;
         unsol_q   <= UNSOL_RST;
         gdata_q   <= GPIO_RST;
         genable_q <= GPIO_RST;
         gdir_q    <= GPIO_RST;
         gmask_q   <= GPIO_RST;
      end
      else
      begin
         if (wr_power)
            power_q <= cmd_pay[3:0];
         if (wr_unsol)
            unsol_q <= cmd_pay & UNSOL_WR_MASK;
         if (wr_gdata)
            gdata_q <= (gdata_q & ~gdir_q) | (cmd_pay[1:0] & gdir_q);
         if (wr_genable)
            genable_q <= cmd_pay[1:0];
         if (wr_gdir)
            gdir_q <= cmd_pay[1:0];
         if (wr_gmask)
            gmask_q <= cmd_pay[1:0];
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         vcfg_q <= VCFG_RST;
      else if (wr_vcfg)
         vcfg_q <= cmd_pay;
   end

   ////////////////////////////////////////////////////////////////////////
   // GPIO pins and power outputs

   // Pin 1 is lost to the second digital output while that role is chosen
   wire       tx2_sel   = vcfg_q[VCFG_TX2_POS];
   wire [1:0] pin_avail = {!tx2_sel, 1'b1};
   wire [7:0] pin_count = tx2_sel ? 8'h01 : 8'h02;
   wire [1:0] levels    = gpio_s & pin_avail;

   assign gpio_o    = gdata_q;
   assign gpio_oe_o = genable_q & gdir_q & pin_avail;
   assign second_digital_audio_out_o = tx2_sel;

   assign requested_power_state_o = power_q;
   assign amp_power_on_o = (power_q == POWER_RST);
   assign ref_power_on_o = (power_q <= POWER_D1);

   ////////////////////////////////////////////////////////////////////////
   // Answer selection

   logic [31:0] answer;
   wire  [31:0] power_word = POWER_FIXED_BITS |
                             {24'h000000, power_q, power_q};

   // Anything not listed, vendor verbs included, answers zero
   always_comb
   begin
      answer = 32'h0000_0000;
      if (is_root && (cmd_verb == VERB_GET_PARAM))
      begin
         case (cmd_pay)
            PARAM_IDENT: answer = {MAKER_CODE, PART_CODE};
            PARAM_REV:   answer = REVISION_PARAM;
            PARAM_CHILD: answer = ROOT_CHILD_COUNT;
            default:     answer = 32'h0000_0000;
         endcase
      end
      else if (is_group)
      begin
         case (cmd_verb)
            VERB_GET_PARAM:
            begin
               case (cmd_pay)
                  PARAM_CHILD:   answer = GROUP_CHILD_COUNT;
                  PARAM_TYPE:    answer = GROUP_TYPE_PARAM;
                  PARAM_GCAPS:   answer = GROUP_CAPS_PARAM;
                  PARAM_PSTATES: answer = POWER_STATES_PARAM;
                  PARAM_GPIOCAP:
                     answer = {GPIO_CAPS_BASE[31:8], pin_count};
                  default:       answer = 32'h0000_0000;
               endcase
            end
            VERB_GET_BOARD:   answer = board_id_q;
            VERB_GET_POWER:   answer = power_word;
            VERB_GET_UNSOL:   answer = {24'h000000, unsol_q};
            VERB_GET_GDATA:   answer = {30'h0, levels};
            VERB_GET_GENABLE: answer = {30'h0, genable_q};
            VERB_GET_GDIR:    answer = {30'h0, gdir_q};
            VERB_GET_GMASK:   answer = {30'h0, gmask_q};
            VERB_GET_VCFG:    answer = {24'h000000, vcfg_q};
            default:          answer = 32'h0000_0000;
         endcase
      end
      else if (is_outconv && (cmd_verb == VERB_GET_PARAM) &&
               (cmd_pay == PARAM_WCAPS))
         answer = OUT_CONVERTER_CAPS;
   end

   ////////////////////////////////////////////////////////////////////////
   // Response queue: one solicited word and one pin-change report

   logic [31:0] sol_word_q;
   logic        sol_pend_q;
   logic        unsol_pend_q;

   // Inputs and outputs alike report changes; unavailable pins and pins with a clear mask bit are ignored
   wire [1:0] gpio_change = (gpio_s ^ gpio_prev_q) & pin_avail;
   wire       unsol_event = unsol_q[UNSOL_EN_POS] &&
                            |(gpio_change & gmask_q);
   wire       take_sol    = lnk.resp_taken && sol_pend_q;
   wire       take_unsol  = lnk.resp_taken && !sol_pend_q;
   wire       new_sol     = for_me && in_map;

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gpio_prev_q  <= GPIO_RST;
         sol_word_q   <= 32'h0000_0000;
         sol_pend_q   <= 1'b0;
         unsol_pend_q <= 1'b0;
      end
      else
      begin
         gpio_prev_q <= gpio_s;
         if (new_sol)
            sol_word_q <= answer;
         // A new event or command wins over the slot being taken
         sol_pend_q   <= new_sol || (sol_pend_q && !take_sol);
         unsol_pend_q <= unsol_event ||
                         (unsol_pend_q && !take_unsol);
      end
   end

   wire [35:0] sol_resp   = {1'b1, 1'b0, 2'h0, sol_word_q};
   wire [35:0] unsol_resp = {1'b1, 1'b1, 2'h0, unsol_q[5:0], 26'h0};

   assign lnk.resp_valid = sol_pend_q || unsol_pend_q;
   assign lnk.resp_word  = sol_pend_q ? sol_resp : unsol_resp;

endmodule : carvr_responder

// ---- tb/carvr_chk.sv ----
// Port-level checks of the verb responder
`timescale 1ns/100ps
module carvr_chk (
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic       link_sync_i,
   input wire logic       link_sdi_o,
   input wire logic       link_sdi_oe_o,
   input wire logic [1:0] gpio_oe_o,
   input wire logic       second_digital_audio_out_o,
   input wire logic [3:0] requested_power_state_o,
   input wire logic       amp_power_on_o,
   input wire logic       ref_power_on_o
);
   localparam int OE_MIN = 280;
   localparam int OE_MAX = 296;
   logic [8:0] oe_cnt_q;
   logic [8:0] oe_cnt_d;
   ////////////////////////////////////////////////////////////////////////
   // A reply spans 36 bit periods of eight clocks each at the bench rate
   assign oe_cnt_d = link_sdi_oe_o ? oe_cnt_q + 9'h001 : 9'h000;
   always_ff @(posedge clock_i or posedge rst_i)
      if (rst_i)
         oe_cnt_q <= 9'h000;
      else
         oe_cnt_q <= oe_cnt_d;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   sequence s_full;
      (requested_power_state_o == 4'h0) [*2];
   endsequence
   sequence s_deep;
      (requested_power_state_o > 4'h1) [*2];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   AST_AMP_OFF: assert property
      ((requested_power_state_o != 4'h0) [*2] |-> !amp_power_on_o)
      else $error("amplifier on outside full power");
   AST_FULL_ON: assert property
      (s_full |-> amp_power_on_o && ref_power_on_o)
      else $error("power rails off in full power");
   AST_REF_OFF: assert property
      (s_deep |-> !ref_power_on_o)
      else $error("reference on in deep power state");
   AST_PS_RANGE: assert property
      (requested_power_state_o <= 4'h3)
      else $error("power state beyond D3");
   AST_RST_VAL: assert property
      ($fell(rst_i) |-> second_digital_audio_out_o && gpio_oe_o == 2'b00
         && requested_power_state_o == 4'h0)
      else $error("wrong values after reset");
   AST_PIN1_SHARED: assert property
      (second_digital_audio_out_o |-> !gpio_oe_o[1])
      else $error("shared pin driven as general pin");
   AST_RESP_START: assert property
      ($rose(link_sdi_oe_o) |-> link_sdi_o && !link_sync_i)
      else $error("reply does not open with valid bit");
   AST_BIT_HOLD: assert property
      (link_sdi_oe_o && $changed(link_sdi_o) |=> $stable(link_sdi_o) [*5])
      else $error("reply bit shorter than a bit period");
   AST_OE_LEN: assert property
      (oe_cnt_q <= OE_MAX)
      else $error("reply drive too long");
   AST_OE_END: assert property
      ($fell(link_sdi_oe_o) |-> oe_cnt_q >= OE_MIN)
      else $error("reply drive too short");
endmodule : carvr_chk

// ---- tb/carvr_host.sv ----
// Link host model: frames one command and captures the codec reply
`timescale 1ns/100ps
module carvr_host (
   output logic        bclk_o,
   output logic        sync_o,
   output logic        sdo_o,
   input  wire logic   sdi_i,
   input  wire logic   sdi_oe_i,
   output logic [35:0] resp_o,
   output logic        done_o
);
   initial
   begin
      bclk_o = 1'b0;
      sync_o = 1'b0;
      sdo_o  = 1'b0;
      resp_o = 36'h0;
      done_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Bit clock runs only inside a frame and stands still between them
   task automatic frame(input logic [39:0] cmd);
      logic [35:0] r;
      r = 36'h0;
      for (int k = -1; k <= 40; k++)
      begin
         sync_o = (k < 0);
         if (k > 0)
            sdo_o = cmd[40-k];
         #80 bclk_o = 1'b1;
         if (k > 0 && k < 37 && sdi_oe_i)
            r[36-k] = sdi_i;
         #80 bclk_o = 1'b0;
      end
      // Released line must not keep showing the last bit
      sdo_o  = ~sdo_o;
      resp_o = r;
      done_o = ~done_o;
   endtask : frame
endmodule : carvr_host

// ---- tb/carvr_tb.sv ----
// Self-checking bench for the verb responder
`timescale 1ns/100ps
module tb;
   import carvr_pkg::*;
   // Arbitrary identity values for this build
   localparam logic [15:0] MK = 16'h3C3C;
   localparam logic [15:0] PT = 16'h0A0B;
   localparam logic [6:0]  G  = 7'h01;
   localparam logic [36:0] DC = 37'h0;
   localparam logic [36:0] NO = {1'b1, 36'h0};
   logic        clock_i = 1'b0;
   logic        rst_i   = 1'b1;
   logic        bclk, sync, sdo, sdi, sdi_oe, sdao, amp, refp, done;
   logic [1:0]  gx = 2'b00;
   logic [1:0]  gpio_o, gpio_oe, pin;
   logic [3:0]  pst;
   logic [3:0]  ad = 4'h0;
   logic [35:0] resp;
   logic [36:0] ex;
   logic [31:0] b;
   logic [58:0] tbl [21];
   logic [36:0] exq [$];
   int          miscompares = 0;
   int          checks_done = 0;
   ////////////////////////////////////////////////////////////////////////
   always #10 clock_i = ~clock_i;
   assign pin = (gpio_oe & gpio_o) | (~gpio_oe & gx);
   carvr_host hst (.bclk_o(bclk), .sync_o(sync), .sdo_o(sdo), .sdi_i(sdi),
      .sdi_oe_i(sdi_oe), .resp_o(resp), .done_o(done));
   carvr_responder #(.MAKER_CODE(MK), .PART_CODE(PT)) DUT (
      .clock_i(clock_i), .rst_i(rst_i), .link_bclk_i(bclk),
      .link_sync_i(sync), .link_sdo_i(sdo), .link_sdi_o(sdi),
      .link_sdi_oe_o(sdi_oe), .gpio_i(pin), .gpio_o(gpio_o),
      .gpio_oe_o(gpio_oe), .second_digital_audio_out_o(sdao),
      .requested_power_state_o(pst), .amp_power_on_o(amp),
      .ref_power_on_o(refp));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [36:0] sol(input logic [31:0] d);
      return {5'b11000, d};
   endfunction : sol
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Note is for the reply carried by the following frame
   task automatic cmd(input logic [6:0] nd, input logic [11:0] vb,
                      input logic [7:0] pl, input logic [36:0] e);
      exq.push_back(e);
      @(posedge clock_i);
      #3;
      hst.frame({8'h00, ad, 1'b0, nd, vb, pl});
   endtask : cmd
   task automatic results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #1;
      forever
      begin
         @(done);
         ex = exq.pop_front();
         if (ex[36])
            chk(resp, ex[35:0]);
      end
   end
   initial
   begin
      #1_000_000;
      miscompares++;
      results();
   end
   initial
   begin
      b = $urandom(96022);
      tbl = '{{7'h00, 12'hF00, 8'h00, MK, PT},
         {7'h00, 12'hF00, 8'h02, 32'h0010_0000},
         {7'h00, 12'hF00, 8'h04, 32'h0001_0001},
         {G, 12'hF00, 8'h04, 32'h0008_002E},
         {G, 12'hF00, 8'h05, 32'h0000_0001},
         {G, 12'hF00, 8'h08, 32'h0001_0306},
         {G, 12'hF00, 8'h0F, 32'hC000_000F},
         {G, 12'hF00, 8'h11, 32'h4000_0001},
         {7'h08, 12'hF00, 8'h09, 32'h0000_041D},
         {7'h0C, 12'hF00, 8'h09, 32'h0000_041D},
         {7'h35, 12'hF00, 8'h09, 32'h0},
         {G, 12'hF00, 8'h0A, 32'h0},
         {G, 12'hF70, 8'h00, 32'h0},
         {G, 12'hFBC, 8'h00, 32'h0},
         {G, 12'hF05, 8'h00, 32'h0000_0400},
         {G, 12'hF08, 8'h00, 32'h0},
         {G, 12'hF16, 8'h00, 32'h0},
         {G, 12'hF17, 8'h00, 32'h0},
         {G, 12'hF19, 8'h00, 32'h0},
         {G, 12'hF83, 8'h00, 32'h10},
         {G, 12'hF20, 8'h00, MK, 16'h0000}};
      repeat (2) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      exq.push_back(NO);
      foreach (tbl[i])
         cmd(tbl[i][58:52], tbl[i][51:40], tbl[i][39:32], sol(tbl[i][31:0]));
      cmd(7'h02, 12'hF00, 8'h00, NO);
      $display("parameter test done");
      for (int i = 0; i < 4; i++)
         cmd(G, 12'h720 + 12'(i), b[8*i +: 8], DC);
      cmd(G, 12'hF20, 8'h00, sol(b));
      for (int p = 3; p >= 0; p--)
      begin
         cmd(G, 12'h705, 8'(p), DC);
         cmd(G, 12'hF05, 8'h00, sol(32'h400 | 32'(p * 17)));
         chk({30'h0, pst, amp, refp}, {30'h0, 4'(p), p == 0, p < 2});
      end
      cmd(G, 12'h705, 8'h04, sol(32'h0));
      cmd(G, 12'hF05, 8'h00, sol(32'h400));
      $display("power test done");
      cmd(G, 12'h708, 8'hFF, DC);
      cmd(G, 12'hF08, 8'h00, sol(32'hBF));
      cmd(G, 12'h716, 8'h03, DC);
      cmd(G, 12'h717, 8'h03, DC);
      cmd(G, 12'h783, 8'h00, DC);
      cmd(G, 12'hF00, 8'h11, sol(32'h4000_0002));
      chk({35'h0, sdao}, 36'h0);
      cmd(G, 12'h717, 8'h01, DC);
      cmd(G, 12'h715, 8'h03, DC);
      @(posedge clock_i) gx <= b[1:0];
      cmd(G, 12'hF15, 8'h00, sol({30'h0, b[1], 1'b1}));
      chk({32'h0, gpio_oe, gpio_o}, 36'h5);
      // Change with the pin mask clear must stay silent
      @(posedge clock_i) gx <= ~b[1:0];
      cmd(7'h36, 12'hF00, 8'h00, NO);
      cmd(G, 12'h719, 8'h02, DC);
      @(posedge clock_i) gx <= b[1:0];
      cmd(7'h36, 12'hF00, 8'h00, {5'b11100, 6'h3F, 26'h0});
      cmd(7'h36, 12'hF00, 8'h00, NO);
      ad = 4'h5;
      cmd(G, 12'hF00, 8'h00, NO);
      ad = 4'h0;
      $display("gpio test done");
      cmd(G, 12'h705, 8'h03, DC);
      cmd(G, 12'h7FF, 8'h00, DC);
      cmd(G, 12'hF08, 8'h00, sol(32'h0));
      cmd(G, 12'hF16, 8'h00, sol(32'h0));
      cmd(G, 12'hF20, 8'h00, sol(b));
      chk({30'h0, pst, gpio_oe}, 36'h0);
      cmd(7'h36, 12'hF00, 8'h00, DC);
      $display("reset test done");
      #200;
      results();
   end
endmodule : tb
bind carvr_responder carvr_chk u_chk (
   .clock_i(clock_i), .rst_i(rst_i), .link_sync_i(link_sync_i),
   .link_sdi_o(link_sdi_o), .link_sdi_oe_o(link_sdi_oe_o),
   .gpio_oe_o(gpio_oe_o),
   .second_digital_audio_out_o(second_digital_audio_out_o),
   .requested_power_state_o(requested_power_state_o),
   .amp_power_on_o(amp_power_on_o), .ref_power_on_o(ref_power_on_o));
